//--- hw/fieldbus_remote_register_cmd.sv
// Purpose: device end, interprets the master-to-device remote words
// Assumes: inverter side answers monitor and alarm lookups in the same cycle
// Notes: one command slot runs at a time via cmd_valid_o / cmd_done_i
// Functional notes
// RULE1 - word 0 bytes pick monitors one, two
// RULE2 - request D loads frequency, then completion D
// RULE3 - request F runs command in word 2
// RULE4 - master loads code and operand before request
// RULE5 - master zeroes operand for operandless commands
// RULE6 - words 4 to 7 pick monitors three-six
// RULE7 - alarm select word picks history entry
// RULE8 - setpoint signed, 0.01 percent, within 150
// RULE9 - chain runs words 2,10,12,14,16,18 in order
// RULE10 - completion F only after word 18 finishes
// RULE11 - code FFF cancels a chained slot
// RULE12 - chained operands come from odd words
// RULE13 - master zeroes unused chained operands
// RULE14 - response zero on success, nonzero error
// RULE15 - alarm code low byte, selection echoed high
// RULE16 - completion drops when its request drops
// RULE17 - unused words A and B ignored
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module fieldbus_remote_register_cmd
  import fieldbus_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  fieldbus_link_if.device link,
  // monitor lookup
  output logic [NUM_MON-1:0][15:0] mon_code_o,
  input wire logic [NUM_MON-1:0][15:0] mon_value_i,
  // alarm history lookup
  output logic [1:0] alarm_sel_o,
  input wire logic [NUM_ALARM_INFO-1:0][15:0] alarm_info_i,
  // frequency and setpoint
  output logic [15:0] freq_o,
  output logic freq_load_o,
  output logic [15:0] setpoint_o,
  // command execution
  output logic cmd_valid_o,
  output logic [15:0] cmd_code_o,
  output logic [15:0] cmd_operand_o,
  input wire logic cmd_done_i,
  input wire logic [15:0] cmd_resp_i,
  input wire logic [15:0] cmd_rdata_i
);
  typedef struct packed {
    dev_state_t st;
    logic [2:0] slot;
    logic [2:0] req_q;
    logic rxd;
    logic rxf;
    word_array_t rwr;
    logic [15:0] freq;
    logic freq_load;
    logic [15:0] setpoint;
    logic cmd_valid;
    logic [15:0] cmd_code;
    logic [15:0] cmd_operand;
  } dev_reg_t;

  dev_reg_t r;
  dev_reg_t next_r;
  logic [4:0] cw;
  logic [15:0] sel;

  // read word of monitor item k
  function automatic logic [4:0] mon_word(input int k);
    mon_word = (k < 2) ? 5'(k) : 5'(W_MON_THREE + 5'(k - 2));
  endfunction : mon_word

  assign cw = slot_word(r.slot);
  assign sel = link.rww[W_ALARM_SEL];

  always_comb begin
    mon_code_o[0] = {8'h00, link.rww[W_MON_PAIR][7:0]}; // [RULE1]
    mon_code_o[1] = {8'h00, link.rww[W_MON_PAIR][15:8]}; // [RULE1]
    for (int k = 2; k < NUM_MON; k++) begin
      mon_code_o[k] = link.rww[mon_word(k)]; // [RULE6]
    end
  end

  assign alarm_sel_o = sel[9:8]; // [RULE7]

  always_comb begin
    next_r = r;
    next_r.req_q = {link.ryf, link.ryd, link.ryc};
    next_r.freq_load = 1'b0;
    // monitors latched on the rising request
    if (link.ryc && !r.req_q[0]) begin
      for (int k = 0; k < NUM_MON; k++) begin
        next_r.rwr[mon_word(k)] = mon_value_i[k]; // [RULE1] [RULE6]
      end
    end
    // frequency load and its completion
    if (link.ryd && !r.req_q[1]) begin
      next_r.freq = link.rww[W_FREQ]; // [RULE2]
      next_r.freq_load = 1'b1;
      next_r.rxd = 1'b1; // [RULE2]
    end
    if (!link.ryd) begin
      next_r.rxd = 1'b0; // [RULE16]
    end
    // setpoint kept within span; words A and B are never read
    next_r.setpoint = clamp_setpoint(link.rww[W_SETPOINT]); // [RULE8] [RULE17]
    // alarm history refreshed while the selection is legal
    if (sel[7:0] == ALARM_LOW_FIXED && sel[15:8] <= ALARM_SEL_MAX) begin
      next_r.rwr[W_ALARM_SEL] = {sel[15:8], alarm_info_i[0][7:0]}; // [RULE7] [RULE15]
      for (int k = 1; k < NUM_ALARM_INFO; k++) begin
        next_r.rwr[W_ALARM_SEL + 5'(k)] = alarm_info_i[k]; // [RULE7]
      end
    end
    // command chain
    unique case (r.st)
      S_IDLE: begin
        if (link.ryf && !r.req_q[2]) begin
          next_r.slot = 3'h0; // [RULE3]
          next_r.st = S_CMD;
        end
      end
      S_CMD: begin
        if (r.slot == NUM_SLOTS) begin
          next_r.rxf = link.ryf; // [RULE10]
          next_r.st = S_IDLE;
        end else if (r.slot != 3'h0 && link.rww[cw] == CMD_CANCEL) begin
          next_r.slot = r.slot + 3'h1; // [RULE11]
        end else begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd_code = link.rww[cw]; // [RULE3] [RULE9]
          next_r.cmd_operand = link.rww[cw + 5'h01]; // [RULE12]
          next_r.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cmd_done_i) begin
          next_r.cmd_valid = 1'b0;
          next_r.rwr[cw] = cmd_resp_i; // [RULE14]
          if (cmd_resp_i == 16'h0000) begin
            next_r.rwr[cw + 5'h01] = cmd_rdata_i; // [RULE14]
          end
          next_r.slot = r.slot + 3'h1; // [RULE9]
          next_r.st = S_CMD;
        end
      end
    endcase
    if (!link.ryf) begin
      next_r.rxf = 1'b0; // [RULE16]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.rwr = r.rwr;
  assign link.rxd = r.rxd;
  assign link.rxf = r.rxf;
  assign freq_o = r.freq;
  assign freq_load_o = r.freq_load;
  assign setpoint_o = r.setpoint;
  assign cmd_valid_o = r.cmd_valid;
  assign cmd_code_o = r.cmd_code;
  assign cmd_operand_o = r.cmd_operand;
endmodule : fieldbus_remote_register_cmd

//--- hw/fieldbus_pkg.sv
// Purpose: shared constants and types for the fieldbus remote word link
// Assumes: word indices follow the printed hexadecimal word numbers
// Notes: both ends and the bench import this package
package fieldbus_pkg;
  localparam int NUM_WORDS = 26;
  localparam logic [4:0] W_MON_PAIR = 5'h00;
  localparam logic [4:0] W_FREQ = 5'h01;
  localparam logic [4:0] W_CMD_FIRST = 5'h02;
  localparam logic [4:0] W_MON_THREE = 5'h04;
  localparam logic [4:0] W_ALARM_SEL = 5'h08;
  localparam logic [4:0] W_SETPOINT = 5'h09;
  localparam logic [4:0] W_UNUSED_A = 5'h0A;
  localparam logic [4:0] W_UNUSED_B = 5'h0B;
  localparam logic [4:0] W_CMD_SECOND = 5'h10;
  localparam logic [4:0] W_LAST = 5'h19;
  localparam logic [2:0] NUM_SLOTS = 3'h6;
  localparam int NUM_MON = 6;
  localparam int NUM_ALARM_INFO = 5;
  localparam logic [15:0] CMD_CANCEL = 16'h0FFF;
  localparam logic [7:0] ALARM_LOW_FIXED = 8'h00;
  localparam logic [7:0] ALARM_SEL_MAX = 8'h03;
  localparam logic [15:0] SETPOINT_MAX = 16'h3A98;
  localparam logic [15:0] SETPOINT_MIN = 16'hC568;
  // avalon word addresses of the controller
  localparam logic [6:0] AV_RWW_BASE = 7'h00;
  localparam logic [6:0] AV_RWR_BASE = 7'h20;
  localparam logic [6:0] AV_CTRL = 7'h40;
  localparam logic [6:0] AV_STATUS = 7'h41;
  localparam logic [6:0] AV_MASK = 7'h42;
  localparam int CTRL_RYC = 0;
  localparam int CTRL_RYD = 1;
  localparam int CTRL_RYF = 2;
  localparam int ST_FREQ_DONE = 0;
  localparam int ST_CMD_DONE = 1;
  localparam int ST_CMD_ERR = 2;
  localparam int NUM_EVENTS = 3;

  typedef logic [NUM_WORDS-1:0][15:0] word_array_t;
  typedef enum logic [1:0] {S_IDLE, S_CMD, S_WAIT} dev_state_t;

  // command word of chain slot s, its operand word follows it
  function automatic logic [4:0] slot_word(input logic [2:0] s);
    slot_word = (s == 3'h0) ? W_CMD_FIRST : 5'(W_CMD_SECOND + 5'({s - 3'h1, 1'b0}));
  endfunction : slot_word

  // signed setpoint held inside its legal span
  function automatic logic [15:0] clamp_setpoint(input logic [15:0] v);
    if ($signed(v) > $signed(SETPOINT_MAX)) clamp_setpoint = SETPOINT_MAX;
    else if ($signed(v) < $signed(SETPOINT_MIN)) clamp_setpoint = SETPOINT_MIN;
    else clamp_setpoint = v;
  endfunction : clamp_setpoint
endpackage : fieldbus_pkg

//--- hw/fieldbus_link_if.sv
// Purpose: remote word and request/completion bits between master and device
// Assumes: one clock shared by both ends
// Notes: rww from master, rwr from device
`timescale 1ns/1ps
interface fieldbus_link_if;
  import fieldbus_pkg::*;
  word_array_t rww;
  word_array_t rwr;
  logic ryc;
  logic ryd;
  logic ryf;
  logic rxd;
  logic rxf;
  modport master (output rww, ryc, ryd, ryf, input rwr, rxd, rxf);
  modport device (input rww, ryc, ryd, ryf, output rwr, rxd, rxf);
endinterface : fieldbus_link_if

//--- hw/fieldbus_master_ctrl.sv
// Purpose: master end, drives remote words and requests from avalon registers
// Assumes: software writes words before starting a request
// Notes: level irq from sticky status gated by mask
`timescale 1ns/1ps
module fieldbus_master_ctrl
  import fieldbus_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [6:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // interrupt
  output logic irq_o,
  // link
  fieldbus_link_if.master link
);
  typedef struct packed {
    word_array_t rww;
    logic ryc;
    logic ryd;
    logic ryf;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] mask;
    logic [31:0] rdata;
    logic rvalid;
  } mst_reg_t;

  mst_reg_t r;
  mst_reg_t next_r;
  logic [NUM_EVENTS-1:0] ev;
  logic [4:0] widx;
  logic [4:0] ridx;
  logic err;

  // command and operand words, locked while a command request runs
  function automatic logic is_cmd_word(input logic [4:0] a);
    is_cmd_word = (a == W_CMD_FIRST) || (a == W_CMD_FIRST + 5'h01) || (a >= W_CMD_SECOND);
  endfunction : is_cmd_word

  assign widx = 5'(address_i - AV_RWW_BASE);
  assign ridx = 5'(address_i - AV_RWR_BASE);

  always_comb begin
    err = 1'b0;
    // cancelled slots keep stale responses, leave them out
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (s == 0 || r.rww[slot_word(3'(s))] != CMD_CANCEL) begin
        err = err | (link.rwr[slot_word(3'(s))] != 16'h0000);
      end
    end
  end

  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    ev = '0;
    // drop each request once its completion is seen
    if (r.ryd && link.rxd) begin
      next_r.ryd = 1'b0; // [RULE16]
      ev[ST_FREQ_DONE] = 1'b1;
    end
    if (r.ryf && link.rxf) begin
      next_r.ryf = 1'b0; // [RULE16]
      ev[ST_CMD_DONE] = 1'b1;
      ev[ST_CMD_ERR] = err;
    end
    if (write_i) begin
      if (address_i <= AV_RWW_BASE + 7'(W_LAST)) begin
        if (!(r.ryf && is_cmd_word(widx)) && widx != W_UNUSED_A && widx != W_UNUSED_B) begin
          next_r.rww[widx] = writedata_i[15:0]; // [RULE4] [RULE17]
          if (widx == W_SETPOINT) begin
            next_r.rww[widx] = clamp_setpoint(writedata_i[15:0]); // [RULE8]
          end
        end
      end else if (address_i == AV_CTRL) begin
        next_r.ryc = writedata_i[CTRL_RYC];
        if (writedata_i[CTRL_RYD]) next_r.ryd = 1'b1; // [RULE2]
        if (writedata_i[CTRL_RYF]) next_r.ryf = 1'b1; // [RULE4]
      end else if (address_i == AV_STATUS) begin
        next_r.status = r.status & ~writedata_i[NUM_EVENTS-1:0];
      end else if (address_i == AV_MASK) begin
        next_r.mask = writedata_i[NUM_EVENTS-1:0];
      end
    end
    next_r.status = next_r.status | ev;
    if (read_i && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = 32'h0000_0000;
      if (address_i <= AV_RWW_BASE + 7'(W_LAST)) begin
        next_r.rdata = {16'h0000, r.rww[widx]};
      end else if (address_i >= AV_RWR_BASE && address_i <= AV_RWR_BASE + 7'(W_LAST)) begin
        next_r.rdata = {16'h0000, link.rwr[ridx]};
      end else if (address_i == AV_CTRL) begin
        next_r.rdata = {29'h0, r.ryf, r.ryd, r.ryc};
      end else if (address_i == AV_STATUS) begin
        next_r.rdata = {29'h0, r.status};
      end else if (address_i == AV_MASK) begin
        next_r.rdata = {29'h0, r.mask};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign waitrequest_o = read_i && !r.rvalid;
  assign readdata_o = r.rdata;
  assign irq_o = |(r.status & r.mask);
  assign link.rww = r.rww;
  assign link.ryc = r.ryc;
  assign link.ryd = r.ryd;
  assign link.ryf = r.ryf;
endmodule : fieldbus_master_ctrl

//--- dv/fieldbus_link_assertions.sv
// Purpose: protocol checks on the remote word link between both ends
// Assumes: one clock, reset active low
// Notes: watches link signals only
`timescale 1ns/1ps
module fieldbus_link_assertions
  import fieldbus_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  input wire word_array_t rww,
  input wire word_array_t rwr,
  input wire logic ryc,
  input wire logic ryd,
  input wire logic ryf,
  input wire logic rxd,
  input wire logic rxf
);
  logic sel_ok;
  assign sel_ok = (rww[W_ALARM_SEL][7:0] == ALARM_LOW_FIXED)
    && (rww[W_ALARM_SEL][15:8] <= ALARM_SEL_MAX);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_freq_done: assert property ($rose(ryd) |=> rxd)
    else $error("rxd did not follow ryd");
  chk_rxd_release: assert property (rxd && !ryd |=> !rxd)
    else $error("rxd held after ryd dropped");
  chk_rxf_release: assert property (rxf && !ryf |=> !rxf)
    else $error("rxf held after ryf dropped");
  chk_rxf_needs_ryf: assert property ($rose(rxf) |-> ryf)
    else $error("rxf raised without ryf");
  chk_chain_not_early: assert property ($rose(ryf) |=> !rxf [*3])
    else $error("rxf raised before chain could finish");
  chk_cmd_frozen: assert property (ryf |=> $stable(rww[W_CMD_FIRST]))
    else $error("command word changed while ryf high");
  chk_unused_words: assert property (rww[W_UNUSED_A] == 16'h0000 && rww[W_UNUSED_B] == 16'h0000)
    else $error("unused word took a value");
  chk_setpoint_span: assert property ($signed(rww[W_SETPOINT]) <= $signed(SETPOINT_MAX)
    && $signed(rww[W_SETPOINT]) >= $signed(SETPOINT_MIN))
    else $error("setpoint word out of span");
  chk_alarm_echo: assert property (sel_ok && $stable(rww[W_ALARM_SEL])
    |-> rwr[W_ALARM_SEL][15:8] == rww[W_ALARM_SEL][15:8])
    else $error("alarm selection not echoed");
endmodule : fieldbus_link_assertions

//--- dv/tb_top.sv
// Purpose: self-checking bench for master and device joined by the link
// Assumes: 50 MHz clock, reset low for two cycles
// Notes: lookups and command port answered by bench models
`timescale 1ns/1ps
module tb_top;
  import fieldbus_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] address = 7'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic cmd_done = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, d;
  logic waitrequest, irq, freq_load, cmd_valid, err_exp;
  logic [NUM_MON-1:0][15:0] mon_code, mon_value;
  logic [1:0] alarm_sel, a;
  logic [NUM_ALARM_INFO-1:0][15:0] alarm_info;
  logic [15:0] freq, setpoint, cmd_code, cmd_op, cmd_resp, cmd_rdata;
  logic [15:0] ran_q[$];
  logic [15:0] cd[8];
  logic [15:0] op[8];
  logic [6:0] w;
  integer seed = 64;
  int err_total = 0;
  int total_checks = 0;
  int loads = 0;
  fieldbus_link_if link();
  fieldbus_master_ctrl u_fieldbus_master_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .address_i(address), .read_i(read), .write_i(write), .writedata_i(writedata),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .irq_o(irq), .link(link));
  fieldbus_remote_register_cmd u_fieldbus_remote_register_cmd (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .link(link), .mon_code_o(mon_code), .mon_value_i(mon_value),
    .alarm_sel_o(alarm_sel), .alarm_info_i(alarm_info), .freq_o(freq),
    .freq_load_o(freq_load), .setpoint_o(setpoint), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_operand_o(cmd_op), .cmd_done_i(cmd_done),
    .cmd_resp_i(cmd_resp), .cmd_rdata_i(cmd_rdata));
  fieldbus_link_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .rww(link.rww),
    .rwr(link.rwr), .ryc(link.ryc), .ryd(link.ryd), .ryf(link.ryf), .rxd(link.rxd),
    .rxf(link.rxf));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // lookup and command models, odd codes fail
  always_comb begin
    for (int k = 0; k < NUM_MON; k++) mon_value[k] = mon_code[k] ^ 16'h5A5A;
    for (int k = 0; k < NUM_ALARM_INFO; k++) alarm_info[k] = {4'hA, 4'(k), 6'h00, alarm_sel};
  end
  assign cmd_resp = {15'h0000, cmd_code[0]};
  assign cmd_rdata = ~cmd_op;
  always @(posedge clk_i) begin
    cmd_done <= cmd_valid && !cmd_done && ($random(seed) % 2 == 0);
    if (cmd_valid && cmd_done) ran_q.push_back(cmd_code);
    if (freq_load === 1'b1) loads++;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [6:0] adr, input logic [31:0] dat);
    address <= adr;
    writedata <= dat;
    write <= 1'b1;
    @(posedge clk_i);
    while (waitrequest !== 1'b0) @(posedge clk_i);
    write <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [6:0] adr, output logic [31:0] dat);
    address <= adr;
    read <= 1'b1;
    @(posedge clk_i);
    while (waitrequest !== 1'b0) @(posedge clk_i);
    dat = readdata;
    read <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  task automatic wait_st(input int b);
    logic [31:0] s = 32'h0;
    int n = 0;
    while (s[b] !== 1'b1 && n < 200) begin
      rd(AV_STATUS, s);
      n++;
    end
    check("status done", {31'h0, s[b]}, 32'h1);
  endtask : wait_st
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(7'h50, d);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 8; i++) begin
      op[i] = 16'($random(seed));
      if (i < 2 || i > 3) wr(7'(i), {16'h0, op[i]});
    end
    wr(AV_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    wr(AV_CTRL, 32'h0);
    rd(AV_RWR_BASE, d);
    check("mon1", d, {16'h0, {8'h00, op[0][7:0]} ^ 16'h5A5A});
    rd(AV_RWR_BASE + 7'h01, d);
    check("mon2", d, {16'h0, {8'h00, op[0][15:8]} ^ 16'h5A5A});
    for (int i = 4; i < 8; i++) begin
      rd(AV_RWR_BASE + 7'(i), d);
      check("mon", d, {16'h0, op[i] ^ 16'h5A5A});
    end
    d = 32'($random(seed)) & 32'hFFFF;
    wr(7'(W_FREQ), d);
    wr(AV_CTRL, 32'h2);
    wait_st(ST_FREQ_DONE);
    check("freq", {16'h0, freq}, d);
    check("freq load", 32'(loads), 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(AV_MASK, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    wr(AV_STATUS, 32'h1);
    check("irq clear", {31'h0, irq}, 32'h0);
    op[0] = 16'h7FFF;
    op[1] = 16'h8000;
    op[2] = SETPOINT_MAX;
    op[3] = SETPOINT_MIN;
    op[4] = 16'($random(seed));
    for (int i = 0; i < 5; i++) begin
      wr(7'(W_SETPOINT), {16'h0, op[i]});
      repeat (2) @(posedge clk_i);
      cd[0] = ($signed(op[i]) > 15000) ? 16'h3A98 : ($signed(op[i]) < -15000) ? 16'hC568 : op[i];
      check("setpoint", {16'h0, setpoint}, {16'h0, cd[0]});
    end
    for (int i = 10; i < 12; i++) begin
      wr(7'(i), 32'h1234);
      rd(7'(i), d);
      check("unused", d, 32'h0);
    end
    for (int k = 0; k < 5; k++) begin
      a = (k < 4) ? 2'(k) : 2'h3;
      wr(7'(W_ALARM_SEL), (k < 4) ? {22'h0, 2'(k), 8'h00} : 32'h0001);
      repeat (2) @(posedge clk_i);
      for (int j = 0; j < 5; j++) begin
        rd(AV_RWR_BASE + 7'(W_ALARM_SEL) + 7'(j), d);
        check("alarm", d, {16'h0, (j == 0) ? {6'h0, a, 6'h0, a} : {4'hA, 4'(j), 6'h0, a}});
      end
    end
    for (int it = 0; it < 4; it++) begin
      err_exp = 1'b0;
      for (int s = 0; s < 6; s++) begin
        w = (s == 0) ? 7'(W_CMD_FIRST) : 7'(14 + 2 * s);
        cd[s] = (s > 0 && (it == 0 || $random(seed) % 3 == 0)) ? CMD_CANCEL : 16'($random(seed)) & 16'h00FF;
        op[s] = cd[s][7] ? 16'h0000 : 16'($random(seed));
        wr(w, {16'h0, cd[s]});
        wr(w + 7'h01, {16'h0, op[s]});
      end
      ran_q = {};
      wr(AV_CTRL, 32'h4);
      wait_st(ST_CMD_DONE);
      for (int s = 0; s < 6; s++) begin
        w = AV_RWR_BASE + ((s == 0) ? 7'(W_CMD_FIRST) : 7'(14 + 2 * s));
        if (s == 0 || cd[s] !== CMD_CANCEL) begin
          check("order", {16'h0, ran_q.pop_front()}, {16'h0, cd[s]});
          rd(w, d);
          check("resp", d, {31'h0, cd[s][0]});
          err_exp = err_exp | cd[s][0];
          rd(w + 7'h01, d);
          if (!cd[s][0]) check("rdata", d, {16'h0, ~op[s]});
        end
      end
      check("extra cmds", ran_q.size(), 32'h0);
      rd(AV_STATUS, d);
      check("cmd error", {31'h0, d[ST_CMD_ERR]}, {31'h0, err_exp});
      wr(AV_STATUS, 32'h7);
    end
    close_out();
  end
endmodule : tb_top
